// ===== hw/amd_params.svh
// opcode layout constants, field positions and reset values for the address decoder
// assumes the classic column-per-mode opcode map of an 8-bit accumulator cpu
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH

// opcode high nibble: one column per instruction group or addressing mode
`define AMD_COL_BITTEST 4'h0
`define AMD_COL_BITMOD 4'h1
`define AMD_COL_BRANCH 4'h2
`define AMD_COL_RMW_DIR 4'h3
`define AMD_COL_RMW_ACC 4'h4
`define AMD_COL_RMW_IDX 4'h5
`define AMD_COL_RMW_IX1 4'h6
`define AMD_COL_RMW_IX 4'h7
`define AMD_COL_CTRL_A 4'h8
`define AMD_COL_CTRL_B 4'h9
`define AMD_COL_IMM 4'hA
`define AMD_COL_DIR 4'hB
`define AMD_COL_EXT 4'hC
`define AMD_COL_IX2 4'hD
`define AMD_COL_IX1 4'hE
`define AMD_COL_IX 4'hF

// single opcodes that leave their column's pattern
`define AMD_OP_BRANCH_SUB 8'hAD
`define AMD_OP_STOP 8'h8E
`define AMD_OP_WAIT 8'h8F
`define AMD_OP_MULTIPLY 8'h42

// low nibble of register/memory columns
`define AMD_LO_JUMP 4'hC
`define AMD_LO_CALL 4'hD
`define AMD_LO_STORE_ACC 4'h7
`define AMD_LO_STORE_IDX 4'hF
`define AMD_LO_COMPARE_IDX 4'h3
`define AMD_LO_LOAD_IDX 4'hE

// low nibble of read-modify-write columns
`define AMD_FN_NEGATE 4'h0
`define AMD_FN_INVERT 4'h3
`define AMD_FN_SHR 4'h4
`define AMD_FN_RORC 4'h6
`define AMD_FN_SAR 4'h7
`define AMD_FN_SHL 4'h8
`define AMD_FN_ROLC 4'h9
`define AMD_FN_DECR 4'hA
`define AMD_FN_INCR 4'hC
`define AMD_FN_TEST 4'hD
`define AMD_FN_ZERO 4'hF

// bit-op fields: bit number in [3:1], polarity or set/clear in [0]
`define AMD_BITNUM_MSB 3
`define AMD_BITNUM_LSB 1
`define AMD_POLARITY_BIT 0

// instruction lengths in bytes
`define AMD_LEN_ONE 2'd1
`define AMD_LEN_TWO 2'd2
`define AMD_LEN_THREE 2'd3

// page-zero high address byte and reset values
`define AMD_PAGE0_HIGH 8'h00
`define AMD_RST_BYTE 8'h00
`define AMD_RST_ADDR 16'h0000

`endif

// ===== hw/amd_pkg.sv
// types shared by the address decoder, its checker and its bench
// no assumptions beyond a systemverilog-2012 tool
package amd_pkg;

  typedef enum logic [2:0]
  {
    MODE_INH = 3'b000,
    MODE_IMM = 3'b001,
    MODE_DIR = 3'b010,
    MODE_EXT = 3'b011,
    MODE_IX = 3'b100,
    MODE_IX1 = 3'b101,
    MODE_IX2 = 3'b110,
    MODE_REL = 3'b111
  } amd_mode_t;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_EVAL = 3'b001,
    ST_READ = 3'b010,
    ST_CAPTURE = 3'b011,
    ST_WRITE = 3'b100
  } amd_state_t;

  typedef struct packed
  {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } amd_ccr_t;

  typedef struct packed
  {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] index;
    amd_ccr_t ccr;
  } amd_req_t;

  typedef struct packed
  {
    amd_mode_t mode;
    logic [1:0] length;
    logic hasAddr;
    logic [15:0] effAddr;
    logic [7:0] operand;
    logic useIndexReg;
    logic isBranch;
    logic taken;
    logic [15:0] nextPc;
    logic carryValid;
    logic carry;
    logic regWrite;
    logic [7:0] regResult;
    logic nzValid;
    logic n;
    logic z;
  } amd_result_t;

endpackage

// ===== hw/amd_rmw_alu.sv
// modify step of read-modify-write instructions
// purely combinational; the caller registers whatever it keeps
`timescale 1ns/1ps
`default_nettype none
`include "amd_params.svh"

module amd_rmw_alu
(
  input wire logic [3:0] fn,
  input wire logic [7:0] operand,
  input wire logic carryIn,
  output logic [7:0] result,
  output logic carryOut
);

  // shift, rotate, arithmetic and clear; test leaves the value alone
  always_comb
  begin
    result = operand;
    carryOut = carryIn;
    case (fn)
      `AMD_FN_NEGATE:
      begin
        result = 8'(~operand + 8'h01);
        carryOut = (operand != 8'h00);
      end
      `AMD_FN_INVERT:
      begin
        result = ~operand;
        carryOut = 1'b1;
      end
      `AMD_FN_SHR:
      begin
        result = {1'b0, operand[7:1]};
        carryOut = operand[0];
      end
      `AMD_FN_RORC:
      begin
        result = {carryIn, operand[7:1]};
        carryOut = operand[0];
      end
      `AMD_FN_SAR:
      begin
        result = {operand[7], operand[7:1]};
        carryOut = operand[0];
      end
      `AMD_FN_SHL:
      begin
        result = {operand[6:0], 1'b0};
        carryOut = operand[7];
      end
      `AMD_FN_ROLC:
      begin
        result = {operand[6:0], carryIn};
        carryOut = operand[7];
      end
      `AMD_FN_DECR: result = 8'(operand - 8'h01);
      `AMD_FN_INCR: result = 8'(operand + 8'h01);
      `AMD_FN_ZERO: result = 8'h00;
      default: result = operand; // test and unused codes pass through
    endcase
  end

endmodule
`default_nettype wire

// ===== hw/amd_decoder.sv
// operand-address generation and instruction-format decoding for an 8-bit cpu
// assumes the core hands over opcode plus two following bytes, pc, a, x and ccr,
// and that memory returns read data in the cycle after a read strobe
//
// Functional notes
// - inherent opcodes are one byte, no address, act on cpu state only
// - immediate opcodes are two bytes; second byte is the operand itself
// - direct opcodes are two bytes; address is zero high byte plus second byte
// - extended opcodes are three bytes; high address byte then low byte
// - indexed without offset is one byte; address is zero high byte plus x
// - 8-bit indexed is two bytes; address is x plus offset keeping carry
// - 16-bit indexed is three bytes; high then low offset, plus x
// - taken branch adds sign-extended offset to next address, else falls through
// - branches use relative targets only; jumps take no register operand
// - bit branches are three bytes; bit number and polarity from opcode
// - bit branches copy the tested bit into carry, taken or not
// - modify ops read, alter and write back; test skips the write
// - bit set and clear alter one bit of a page-zero byte only
// - register/memory ops pair a or x with a memory operand
// - stop halts oscillator and enables irq pin; wait halts cpu clock and enables interrupts
// - two branches test the irq pin level, one high, one low
`timescale 1ns/1ps
`default_nettype none
`include "amd_params.svh"

module amd_decoder
  import amd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire amd_req_t req,
  input wire logic irqPin,
  input wire logic wakeup,
  input wire logic [7:0] memRdata,
  output logic busy,
  output logic done,
  output var amd_result_t result,
  output logic [15:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic [7:0] memWdata,
  output logic oscHalt,
  output logic cpuClkHalt,
  output logic irqPinEnable,
  output logic intEnable
);

  amd_state_t state;
  amd_req_t cur;
  logic [7:0] readData;

  // addressing mode of an opcode, by column
  function automatic amd_mode_t modeOf(input logic [7:0] op);
    unique case (op[7:4])
      `AMD_COL_BITTEST, `AMD_COL_BITMOD, `AMD_COL_RMW_DIR, `AMD_COL_DIR: modeOf = MODE_DIR;
      `AMD_COL_BRANCH: modeOf = MODE_REL;
      `AMD_COL_RMW_ACC, `AMD_COL_RMW_IDX, `AMD_COL_CTRL_A, `AMD_COL_CTRL_B: modeOf = MODE_INH;
      `AMD_COL_RMW_IX1, `AMD_COL_IX1: modeOf = MODE_IX1;
      `AMD_COL_RMW_IX, `AMD_COL_IX: modeOf = MODE_IX;
      `AMD_COL_IMM: modeOf = (op == `AMD_OP_BRANCH_SUB) ? MODE_REL : MODE_IMM;
      `AMD_COL_EXT: modeOf = MODE_EXT;
      `AMD_COL_IX2: modeOf = MODE_IX2;
    endcase
  endfunction

  // instruction length in bytes
  function automatic logic [1:0] lenOf(input logic [7:0] op, input amd_mode_t m);
    if (op[7:4] == `AMD_COL_BITTEST)
      lenOf = `AMD_LEN_THREE;
    else
    begin
      unique case (m)
        MODE_INH, MODE_IX: lenOf = `AMD_LEN_ONE;
        MODE_IMM, MODE_DIR, MODE_IX1, MODE_REL: lenOf = `AMD_LEN_TWO;
        MODE_EXT, MODE_IX2: lenOf = `AMD_LEN_THREE;
      endcase
    end
  endfunction

  // effective operand address of a memory mode
  function automatic logic [15:0] addrOf(input amd_mode_t m, input logic [7:0] b1, input logic [7:0] b2,
                                         input logic [7:0] x);
    unique case (m)
      MODE_DIR: addrOf = {`AMD_PAGE0_HIGH, b1};
      MODE_EXT: addrOf = {b1, b2};
      MODE_IX: addrOf = {`AMD_PAGE0_HIGH, x};
      MODE_IX1: addrOf = {`AMD_PAGE0_HIGH, b1} + {`AMD_PAGE0_HIGH, x};
      MODE_IX2: addrOf = 16'({b1, b2} + {`AMD_PAGE0_HIGH, x});
      default: addrOf = `AMD_RST_ADDR; // inherent, immediate and relative carry no address
    endcase
  endfunction

  // relative branch condition; odd opcodes test the inverse of the even one
  function automatic logic branchCond(input logic [3:0] lo, input amd_ccr_t f, input logic pin);
    logic base;
    base = 1'b1;
    unique case (lo[3:1])
      3'h0: base = 1'b1;
      3'h1: base = ~(f.c | f.z);
      3'h2: base = ~f.c;
      3'h3: base = ~f.z;
      3'h4: base = ~f.h;
      3'h5: base = ~f.n;
      3'h6: base = ~f.i;
      3'h7: base = ~pin;
    endcase
    branchCond = base ^ lo[0];
  endfunction

  // decode of the held instruction
  amd_mode_t curMode;
  logic [3:0] col;
  logic [3:0] lo;
  logic [15:0] curAddr;
  logic [15:0] seqPc;
  logic [15:0] relTarget;
  logic [7:0] relOffset;
  logic isBitTest;
  logic isBitMod;
  logic isRmw;
  logic isRmwMem;
  logic isRegMem;
  logic isJump;
  logic isStore;
  logic isRelBranch;
  logic needRead;
  logic needWrite;
  logic [2:0] bitNum;
  logic [7:0] dataIn;
  logic [7:0] rmwOperand;
  logic [7:0] aluResult;
  logic aluCarry;
  logic [7:0] bitModified;
  logic testedBit;

  assign curMode = modeOf(cur.opcode);
  assign col = cur.opcode[7:4];
  assign lo = cur.opcode[3:0];
  assign curAddr = addrOf(curMode, cur.byte1, cur.byte2, cur.index);
  assign seqPc = 16'(cur.pc + {14'h0000, lenOf(cur.opcode, curMode)});
  assign isBitTest = (col == `AMD_COL_BITTEST);
  assign isBitMod = (col == `AMD_COL_BITMOD);
  assign isRmw = (col >= `AMD_COL_RMW_DIR) && (col <= `AMD_COL_RMW_IX) && (cur.opcode != `AMD_OP_MULTIPLY);
  assign isRmwMem = isRmw && (col != `AMD_COL_RMW_ACC) && (col != `AMD_COL_RMW_IDX);
  assign isRegMem = (col >= `AMD_COL_IMM) && (cur.opcode != `AMD_OP_BRANCH_SUB);
  assign isJump = isRegMem && (curMode != MODE_IMM) && ((lo == `AMD_LO_JUMP) || (lo == `AMD_LO_CALL));
  assign isStore = isRegMem && ((lo == `AMD_LO_STORE_ACC) || (lo == `AMD_LO_STORE_IDX));
  assign isRelBranch = (curMode == MODE_REL) && !isBitTest;
  // memory operand read for bit ops, memory modify ops and register/memory ops in memory modes other than jumps and stores
  assign needRead = isBitTest || isBitMod || isRmwMem ||
                    (isRegMem && (curMode != MODE_IMM) && !isJump && !isStore);
  assign needWrite = isBitMod || (isRmwMem && (lo != `AMD_FN_TEST));
  assign bitNum = cur.opcode[`AMD_BITNUM_MSB:`AMD_BITNUM_LSB];
  assign relOffset = isBitTest ? cur.byte2 : cur.byte1;
  assign relTarget = 16'(seqPc + {{8{relOffset[7]}}, relOffset});
  assign dataIn = (state == ST_CAPTURE) ? memRdata : readData;
  assign rmwOperand = isRmwMem ? dataIn : ((col == `AMD_COL_RMW_ACC) ? cur.acc : cur.index);
  assign testedBit = dataIn[bitNum];

  amd_rmw_alu i_amd_rmw_alu
  (
    .fn(lo),
    .operand(rmwOperand),
    .carryIn(cur.ccr.c),
    .result(aluResult),
    .carryOut(aluCarry)
  );

  // bit set on even opcode, clear on odd, other bits untouched
  always_comb
  begin
    bitModified = dataIn;
    bitModified[bitNum] = ~cur.opcode[`AMD_POLARITY_BIT];
  end

  // result assembled from the held instruction and any data read
  amd_result_t next_result;
  always_comb
  begin
    next_result = '0;
    next_result.mode = curMode;
    next_result.length = lenOf(cur.opcode, curMode);
    next_result.hasAddr = (curMode != MODE_INH) && (curMode != MODE_IMM) && (curMode != MODE_REL);
    next_result.effAddr = curAddr;
    next_result.operand = (curMode == MODE_IMM) ? cur.byte1 : dataIn;
    next_result.useIndexReg = isRegMem && !isJump &&
                              ((lo == `AMD_LO_COMPARE_IDX) || (lo == `AMD_LO_LOAD_IDX) ||
                               (lo == `AMD_LO_STORE_IDX));
    next_result.isBranch = isRelBranch || isBitTest;
    next_result.nextPc = seqPc;
    if (isBitTest)
    begin
      next_result.taken = (testedBit != cur.opcode[`AMD_POLARITY_BIT]);
      next_result.carryValid = 1'b1;
      next_result.carry = testedBit;
    end
    else if (isRelBranch)
      next_result.taken = (cur.opcode == `AMD_OP_BRANCH_SUB) || branchCond(lo, cur.ccr, irqPin);
    if (next_result.taken)
      next_result.nextPc = relTarget;
    else if (isJump)
      next_result.nextPc = curAddr;
    if (isRmw)
    begin
      next_result.carryValid = (lo != `AMD_FN_TEST);
      next_result.carry = aluCarry;
      next_result.nzValid = 1'b1;
      next_result.n = aluResult[7];
      next_result.z = (aluResult == 8'h00);
      next_result.regWrite = !isRmwMem && (lo != `AMD_FN_TEST);
      next_result.regResult = aluResult;
    end
  end

  // sequencing: accept, evaluate, optional read and write-back
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state <= ST_IDLE;
    else if (clkEn)
    begin
      unique case (state)
        ST_IDLE: if (reqValid) state <= ST_EVAL;
        ST_EVAL: state <= needRead ? ST_READ : ST_IDLE;
        ST_READ: state <= ST_CAPTURE;
        ST_CAPTURE: state <= needWrite ? ST_WRITE : ST_IDLE;
        ST_WRITE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // request holding and read data capture
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cur <= '0;
      readData <= `AMD_RST_BYTE;
    end
    else if (clkEn)
    begin
      if (state == ST_IDLE && reqValid)
        cur <= req;
      if (state == ST_CAPTURE)
        readData <= memRdata;
    end
  end

  // memory strobes: one-cycle read, then one-cycle write-back to the same address
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      memAddr <= `AMD_RST_ADDR;
      memRead <= 1'b0;
      memWrite <= 1'b0;
      memWdata <= `AMD_RST_BYTE;
    end
    else if (clkEn)
    begin
      memRead <= (state == ST_EVAL) && needRead;
      memWrite <= (state == ST_CAPTURE) && needWrite;
      if (state == ST_EVAL)
        memAddr <= curAddr;
      if (state == ST_CAPTURE)
        memWdata <= isBitMod ? bitModified : aluResult;
    end
  end

  // completion pulse, busy level and result hold
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end
    else if (clkEn)
    begin
      done <= 1'b0;
      if (state == ST_IDLE && reqValid)
        busy <= 1'b1;
      if ((state == ST_EVAL && !needRead) || (state == ST_CAPTURE && !needWrite) || state == ST_WRITE)
      begin
        busy <= 1'b0;
        done <= 1'b1;
        result <= next_result;
      end
    end
  end

  // low-power requests; a new request wins over a same-cycle wakeup
  logic finishing;
  assign finishing = (state == ST_EVAL);
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      oscHalt <= 1'b0;
      irqPinEnable <= 1'b0;
      cpuClkHalt <= 1'b0;
      intEnable <= 1'b0;
    end
    else if (clkEn)
    begin
      if (finishing && cur.opcode == `AMD_OP_STOP)
      begin
        oscHalt <= 1'b1;
        irqPinEnable <= 1'b1;
      end
      else if (wakeup)
      begin
        oscHalt <= 1'b0;
        irqPinEnable <= 1'b0;
      end
      if (finishing && cur.opcode == `AMD_OP_WAIT)
      begin
        cpuClkHalt <= 1'b1;
        intEnable <= 1'b1;
      end
      else if (wakeup)
      begin
        cpuClkHalt <= 1'b0;
        intEnable <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== verification/amd_decoder_asserts.sv
// port checker for amd_decoder, bound to every instance
// assumes clkEn stays high while a request is in flight
`timescale 1ns/1ps
`default_nettype none
module amd_decoder_asserts
  import amd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire amd_req_t req,
  input wire logic wakeup,
  input wire logic [7:0] memRdata,
  input wire logic busy,
  input wire logic done,
  input wire amd_result_t result,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] memWdata,
  input wire logic oscHalt,
  input wire logic cpuClkHalt,
  input wire logic irqPinEnable,
  input wire logic intEnable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // address expected for a register/memory load in columns b..f
  function automatic logic [15:0] eaRef(amd_req_t r);
    case (r.opcode[7:4])
      4'hB: return {8'h00, r.byte1};
      4'hC: return {r.byte1, r.byte2};
      4'hD: return {r.byte1, r.byte2} + {8'h00, r.index};
      4'hE: return {8'h00, r.byte1} + {8'h00, r.index};
      default: return {8'h00, r.index};
    endcase
  endfunction

  // byte after a bit set or clear
  function automatic logic [7:0] modBit(logic [7:0] v, logic [7:0] op);
    return op[0] ? (v & ~(8'h01 << op[3:1])) : (v | (8'h01 << op[3:1]));
  endfunction

  // one bit of a byte
  function automatic logic bitOf(logic [7:0] v, logic [2:0] n);
    return v[n];
  endfunction

  sequence s_take;
    clkEn && reqValid && !busy;
  endsequence

  sequence s_read(logic [15:0] a);
    memRead && memAddr == a;
  endsequence

  property p_imm;
    s_take ##0 req.opcode[7:4] == 4'hA && req.opcode[3:0] < 4'h7 |=> busy && !memRead
      ##1 done && !busy && result.length == 2'd2 && !result.hasAddr && result.operand == $past(req.byte1, 2);
  endproperty
  property p_ea;
    s_take ##0 req.opcode[7:4] > 4'hA && req.opcode[3:0] == 4'h6 |-> ##2 s_read(eaRef($past(req, 2)));
  endproperty
  property p_rel;
    s_take ##0 req.opcode[7:4] == 4'h2 |-> ##2 done && result.isBranch && result.nextPc ==
      $past(req.pc, 2) + 16'h0002 + (result.taken ? {{8{$past(req.byte1[7], 2)}}, $past(req.byte1, 2)} : 16'h0000);
  endproperty
  property p_bitbr;
    s_take ##0 req.opcode[7:4] == 4'h0 |-> ##2 s_read({8'h00, $past(req.byte1, 2)}) ##2 done && result.carryValid
      && result.carry == bitOf($past(memRdata, 1), $past(req.opcode[3:1], 4));
  endproperty
  property p_bitmod;
    s_take ##0 req.opcode[7:4] == 4'h1 |-> ##2 s_read({8'h00, $past(req.byte1, 2)})
      ##2 memWrite && memWdata == modBit($past(memRdata, 1), $past(req.opcode, 4));
  endproperty
  property p_test_only;
    s_take ##0 req.opcode == 8'h3D |-> ##2 memRead ##1 !memWrite ##1 done && !memWrite;
  endproperty
  property p_wb;
    memWrite |-> $past(memRead, 2) && memAddr == $past(memAddr, 2) ##1 done;
  endproperty
  property p_halt;
    s_take ##0 req.opcode[7:1] == 7'h47 ##1 (!wakeup) [*2] |->
      ($past(req.opcode[0], 2) ? (cpuClkHalt && intEnable) : (oscHalt && irqPinEnable));
  endproperty
  property p_wake;
    clkEn && wakeup && !busy |=> !oscHalt && !cpuClkHalt && !irqPinEnable && !intEnable;
  endproperty
  property p_done;
    clkEn && done |=> !done;
  endproperty

  a_imm: assert property (p_imm) else $error("immediate decode wrong");
  a_ea: assert property (p_ea) else $error("operand address wrong");
  a_rel: assert property (p_rel) else $error("branch target wrong");
  a_bitbr: assert property (p_bitbr) else $error("bit test carry wrong");
  a_bitmod: assert property (p_bitmod) else $error("bit modify wrong");
  a_test_only: assert property (p_test_only) else $error("test wrote back");
  a_wb: assert property (p_wb) else $error("write back misplaced");
  a_halt: assert property (p_halt) else $error("halt outputs wrong");
  a_wake: assert property (p_wake) else $error("wakeup did not clear");
  a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule

bind amd_decoder amd_decoder_asserts i_amd_decoder_asserts (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
  .reqValid(reqValid), .req(req), .wakeup(wakeup), .memRdata(memRdata), .busy(busy), .done(done), .result(result),
  .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .oscHalt(oscHalt),
  .cpuClkHalt(cpuClkHalt), .irqPinEnable(irqPinEnable), .intEnable(intEnable));
`default_nettype wire

// ===== verification/amd_mem_model.sv
// byte-wide memory on the decoder's bus
// read data valid only in the cycle after the strobe, no wait states
`timescale 1ns/1ps
`default_nettype none
module amd_mem_model
(
  input wire logic core_clk,
  input wire logic [15:0] memAddr,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  logic [7:0] mem [0:65535];
  initial memRdata = 8'hA5;
  // answer reads, otherwise toggle so stale data never looks valid
  always @(posedge core_clk)
  begin
    memRdata <= memRead ? mem[memAddr] : ~memRdata;
    if (memWrite)
      mem[memAddr] <= memWdata;
  end
endmodule
`default_nettype wire

// ===== verification/amd_decoder_tb_top.sv
// self-checking bench for amd_decoder with a memory model on its bus
// inputs change on the falling edge; clkEn is held high
`timescale 1ns/1ps
`default_nettype none
module amd_decoder_tb_top
  import amd_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic reqValid = 1'b0;
  logic irqPin = 1'b0;
  logic wakeup = 1'b0;
  amd_req_t req = '0;
  logic busy, done, memRead, memWrite, oscHalt, cpuClkHalt, irqPinEnable, intEnable;
  amd_result_t result;
  logic [15:0] memAddr;
  logic [7:0] memWdata, memRdata;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;

  amd_decoder i_amd_decoder (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn), .reqValid(reqValid), .req(req),
    .irqPin(irqPin), .wakeup(wakeup), .memRdata(memRdata), .busy(busy), .done(done), .result(result),
    .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .memWdata(memWdata), .oscHalt(oscHalt),
    .cpuClkHalt(cpuClkHalt), .irqPinEnable(irqPinEnable), .intEnable(intEnable));
  amd_mem_model i_amd_mem_model (.core_clk(core_clk), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
    .memWdata(memWdata), .memRdata(memRdata));

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one request, then wait for done; returns at the falling edge of the done cycle
  task automatic run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    int n = 0;
    req.opcode = op;
    req.byte1 = b1;
    req.byte2 = b2;
    reqValid = 1'b1;
    @(negedge core_clk);
    reqValid = 1'b0;
    while (done !== 1'b1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    check(16'(done), 16'h0001);
  endtask

  // branch condition picked by opcode bits 3:1, bit 0 inverts it
  function automatic logic takenRef(input logic [3:0] lo, input amd_ccr_t f, input logic irq);
    logic b;
    case (lo[3:1])
      3'd0: b = 1'b1;
      3'd1: b = !(f.c | f.z);
      3'd2: b = !f.c;
      3'd3: b = !f.z;
      3'd4: b = !f.h;
      3'd5: b = !f.n;
      3'd6: b = !f.i;
      default: b = !irq;
    endcase
    return b ^ lo[0];
  endfunction

  task automatic t_simple();
    req.acc = 8'hFF;
    req.pc = 16'h0200;
    run(8'h4C, 8'h00, 8'h00);
    check({4'h0, result.regWrite, result.hasAddr, result.length, result.regResult}, 16'h0900);
    run(8'hA6, 8'h5C, 8'h00);
    check({5'h00, result.hasAddr, result.length, result.operand}, 16'h025C);
    run(8'hAE, 8'h11, 8'h00);
    check({7'h00, result.useIndexReg, result.operand}, 16'h0111);
    run(8'hAD, 8'hFC, 8'h00);
    check(result.nextPc, 16'h01FE);
    run(8'hCC, 8'h12, 8'h34);
    check(result.nextPc, 16'h1234);
  endtask

  task automatic t_modes();
    logic [7:0] op [5] = '{8'hB6, 8'hC6, 8'hF6, 8'hE6, 8'hD6};
    logic [23:0] arg [5] = '{24'h100000, 24'h123400, 24'h00009C, 24'hFF00FF, 24'hFFFF02};
    logic [15:0] ea [5] = '{16'h0010, 16'h1234, 16'h009C, 16'h01FE, 16'h0001};
    logic [1:0] ln [5] = '{2'd2, 2'd3, 2'd1, 2'd2, 2'd3};
    amd_mode_t md [5] = '{MODE_DIR, MODE_EXT, MODE_IX, MODE_IX1, MODE_IX2};
    for (int i = 0; i < 5; i++)
    begin
      i_amd_mem_model.mem[ea[i]] = ea[i][7:0] ^ 8'h3C;
      req.index = arg[i][7:0];
      run(op[i], arg[i][23:16], arg[i][15:8]);
      check(memAddr, ea[i]);
      check(result.effAddr, ea[i]);
      check({6'h00, result.length, result.operand}, {6'h00, ln[i], ea[i][7:0] ^ 8'h3C});
      check(16'(result.mode), 16'(md[i]));
    end
  endtask

  task automatic t_branch();
    logic tk;
    req.pc = 16'hFFF0;
    for (int k = 0; k < 32; k++)
    begin
      req.ccr = k[4] ? 5'h15 : 5'h0A;
      irqPin = k[4];
      tk = takenRef(k[3:0], req.ccr, irqPin);
      run({4'h2, k[3:0]}, k[4] ? 8'h80 : 8'h20, 8'h00);
      check(16'(result.taken), 16'(tk));
      check(result.nextPc, tk ? (k[4] ? 16'hFF72 : 16'h0012) : 16'hFFF2);
    end
    irqPin = 1'b0;
  endtask

  task automatic t_bits();
    logic [7:0] tv = 8'hA5;
    logic [7:0] exp;
    req.pc = 16'h0100;
    i_amd_mem_model.mem[16'h0040] = tv;
    for (int k = 0; k < 16; k++)
    begin
      run(8'(k), 8'h40, 8'hF0);
      check(16'(result.carry), 16'(tv[k[3:1]]));
      check(result.nextPc, (tv[k[3:1]] ^ k[0]) ? 16'h00F3 : 16'h0103);
      i_amd_mem_model.mem[16'h0050] = 8'h5A;
      exp = k[0] ? (8'h5A & ~(8'h01 << k[3:1])) : (8'h5A | (8'h01 << k[3:1]));
      run(8'h10 | 8'(k), 8'h50, 8'h00);
      check(16'(i_amd_mem_model.mem[16'h0050]), 16'(exp));
    end
  endtask

  task automatic t_rmw();
    i_amd_mem_model.mem[16'h0060] = 8'h7F;
    run(8'h3C, 8'h60, 8'h00);
    check(16'(i_amd_mem_model.mem[16'h0060]), 16'h0080);
    run(8'h3D, 8'h60, 8'h00);
    check({5'h00, result.nzValid, result.n, result.z, i_amd_mem_model.mem[16'h0060]}, 16'h0680);
    req.index = 8'h60;
    run(8'h7A, 8'h00, 8'h00);
    check(16'(i_amd_mem_model.mem[16'h0060]), 16'h007F);
  endtask

  task automatic t_halt();
    for (int k = 0; k < 2; k++)
    begin
      run(8'h8E | 8'(k), 8'h00, 8'h00);
      @(negedge core_clk);
      check({12'h000, oscHalt, irqPinEnable, cpuClkHalt, intEnable}, k ? 16'h0003 : 16'h000C);
      wakeup = 1'b1;
      @(negedge core_clk);
      wakeup = 1'b0;
      check({12'h000, oscHalt, irqPinEnable, cpuClkHalt, intEnable}, 16'h0000);
    end
  endtask

  // reset, then every scenario in turn
  initial
  begin
    repeat (10) @(negedge core_clk);
    check({8'h00, busy, done, memRead, memWrite, oscHalt, cpuClkHalt, irqPinEnable, intEnable}, 16'h0000);
    rst_b = 1'b1;
    t_simple();
    t_modes();
    t_branch();
    t_bits();
    t_rmw();
    t_halt();
    stop_test();
  end
endmodule
`default_nettype wire
